// ---- core/sbd_copy_engine.sv ----
// Purpose: copy engine between system ram and serial port buffers
// Assumes: one clock, ram and buffers answer combinationally
// Notes: registers on classic wishbone, one word per register
//
// How it works
// - a valid launch clears the copy error flag
// - software writing zero clears the copy error flag
// - base outside 0x100..0x8FF sets the error flag at launch
// - base plus count running past the window sets the error flag
// - a count above sixteen sets the error flag
// - on a range error address and count keep old values
// - error flag with port interrupts enabled raises port interrupt
// - range error pulses the illegal access interrupt unless masked
// - direction one copies ram into the empty transmit buffer
// - direction zero copies older filled receive buffer into ram
// - software sets the run bit, hardware clears it when done
// - the core is stalled while the copy runs
// - a running copy cannot be interrupted
// - address is 12 bits in two bytes, reset 0x100
// - after a copy the address is last location plus one
// - the byte count is kept after completion
// - reserved upper bits read as zero
// - the engine is enabled by the buffer mode configuration bit
// - a copy of N bytes takes N plus one cycles
// - registers are unreachable while the port is disabled
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module sbd_copy_engine
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // classic wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [9:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // port configuration and status
    input wire logic i_port_enable,
    input wire logic i_buffer_mode,
    input wire logic i_port_irq_enable,
    input wire logic i_illegal_irq_mask,
    input wire logic i_tx_empty_sel,
    input wire logic i_rx_older_sel,
    // system ram
    output sbd_pkg::sbd_ram_req_type o_ram,
    input wire logic [7:0] i_ram_rdata,
    // port buffers
    output sbd_pkg::sbd_buf_req_type o_buf,
    input wire logic [7:0] i_buf_rdata,
    // core and interrupts
    output logic o_core_stall,
    output logic o_port_irq,
    output logic o_illegal_irq
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    sbd_pkg::sbd_state_type state_ff;
    logic run_ff;
    logic dir_ff;
    logic err_ff;
    logic [11:0] addr_ff;
    logic [4:0] count_ff;
    logic [4:0] left_ff;
    logic [3:0] idx_ff;
    logic sel_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic illegal_ff;
    logic bad;
    logic wr_req;
    logic rd_req;
    logic reg_ok;
    logic launch;
    logic engine_on;
    logic quit_early;

    // byte lane zero write from the bus
    function automatic logic lane0_write(input logic [3:0] sel);
        lane0_write = sel[0];
    endfunction : lane0_write

    // final byte of a copy, the engine leaves with it
    function automatic logic last_byte(input logic [4:0] left);
        last_byte = (left == 5'h01);
    endfunction : last_byte

    sbd_range_check u_check
    (
        .i_base(addr_ff),
        .i_count(count_ff),
        .o_bad(bad)
    );

    // -----------------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------------
    // registers gated by port enable
    assign reg_ok = i_port_enable;
    assign wr_req = i_wb_cyc && i_wb_stb && i_wb_we && !ack_ff
        && i_clk_en && reg_ok && lane0_write(i_wb_sel);
    assign rd_req = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_ff && i_clk_en;
    assign engine_on = i_buffer_mode;
    assign launch = (state_ff == sbd_pkg::ST_IDLE) && wr_req
        && (i_wb_adr == sbd_pkg::ADR_CTRL) && i_wb_dat[sbd_pkg::BIT_RUN]
        && engine_on;

    // range error or empty copy ends at the check
    assign quit_early = bad || (count_ff == 5'h00);

    // ack one cycle after a strobe, held low the following cycle
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ack_ff <= 1'b0;
        else if (i_clk_en)
            ack_ff <= i_wb_cyc && i_wb_stb && !ack_ff;
    end

    // read data, unmapped and disabled read as zero
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rdat_ff <= 32'h0000_0000;
        else if (rd_req)
        begin
            rdat_ff <= 32'h0000_0000;
            if (!reg_ok)
                rdat_ff <= 32'h0000_0000;
            else if (i_wb_adr == sbd_pkg::ADR_CTRL)
                rdat_ff[sbd_pkg::BIT_ERR:0] <= {err_ff, dir_ff, run_ff};
            else if (i_wb_adr == sbd_pkg::ADR_ADDR_LO)
                rdat_ff[7:0] <= addr_ff[7:0];
            else if (i_wb_adr == sbd_pkg::ADR_ADDR_HI)
                rdat_ff[3:0] <= addr_ff[11:8];
            else if (i_wb_adr == sbd_pkg::ADR_COUNT)
                rdat_ff[4:0] <= count_ff;
        end
    end

    assign o_wb_ack = ack_ff;
    assign o_wb_dat = rdat_ff;

    // -----------------------------------------------------------------
    // control register
    // -----------------------------------------------------------------
    // run bit, set by launch and cleared by hardware
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            run_ff <= 1'b0;
        else if (i_clk_en)
        begin
            if (state_ff == sbd_pkg::ST_SETUP && quit_early)
                run_ff <= 1'b0;
            // last byte also ends the copy
            else if (state_ff == sbd_pkg::ST_MOVE && last_byte(left_ff))
                run_ff <= 1'b0;
            else if (launch)
                run_ff <= 1'b1;
        end
    end

    // direction bit, fixed while copying
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            dir_ff <= 1'b0;
        else if (wr_req && i_wb_adr == sbd_pkg::ADR_CTRL
            && state_ff == sbd_pkg::ST_IDLE)
            dir_ff <= i_wb_dat[sbd_pkg::BIT_DIR];
    end

    // error flag, hardware set wins over software clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            err_ff <= 1'b0;
        else if (i_clk_en)
        begin
            // set on bad range at launch check
            if (state_ff == sbd_pkg::ST_SETUP && bad)
                err_ff <= 1'b1;
            else if (state_ff == sbd_pkg::ST_SETUP)
                err_ff <= 1'b0;
            else if (wr_req && i_wb_adr == sbd_pkg::ADR_CTRL
                && !i_wb_dat[sbd_pkg::BIT_ERR])
                err_ff <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // address and count
    // -----------------------------------------------------------------
    // address: software writes when idle, advances during copy
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            addr_ff <= sbd_pkg::RST_ADDR;
        else if (i_clk_en)
        begin
            // step to last location plus one
            if (state_ff == sbd_pkg::ST_MOVE && left_ff != 5'h00)
                addr_ff <= addr_ff + 12'h001;
            // split over low and high bytes
            else if (state_ff == sbd_pkg::ST_IDLE && wr_req
                && i_wb_adr == sbd_pkg::ADR_ADDR_LO)
                addr_ff[7:0] <= i_wb_dat[7:0];
            else if (state_ff == sbd_pkg::ST_IDLE && wr_req
                && i_wb_adr == sbd_pkg::ADR_ADDR_HI)
                addr_ff[11:8] <= i_wb_dat[3:0];
        end
    end

    // count kept through completion; kept on error
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            count_ff <= sbd_pkg::RST_COUNT;
        else if (state_ff == sbd_pkg::ST_IDLE && wr_req
            && i_wb_adr == sbd_pkg::ADR_COUNT)
            count_ff <= i_wb_dat[4:0];
    end

    // -----------------------------------------------------------------
    // sequencer
    // -----------------------------------------------------------------
    // one check cycle plus N move cycles
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            state_ff <= sbd_pkg::ST_IDLE;
        else if (i_clk_en)
        begin
            case (state_ff)
                sbd_pkg::ST_IDLE:
                    if (launch)
                        state_ff <= sbd_pkg::ST_SETUP;
                // error skips the transfer
                // zero count moves nothing and frees the core
                sbd_pkg::ST_SETUP:
                    if (quit_early)
                        state_ff <= sbd_pkg::ST_IDLE;
                    else
                        state_ff <= sbd_pkg::ST_MOVE;
                // leave with the last byte, no spare cycle
                sbd_pkg::ST_MOVE:
                    if (last_byte(left_ff))
                        state_ff <= sbd_pkg::ST_IDLE;
                default:
                    state_ff <= sbd_pkg::ST_IDLE;
            endcase
        end
    end

    // bytes left, buffer index and buffer choice
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            left_ff <= 5'h00;
            idx_ff <= 4'h0;
            sel_ff <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (state_ff == sbd_pkg::ST_SETUP)
            begin
                left_ff <= count_ff;
                idx_ff <= 4'h0;
                // empty tx buffer, older rx buffer
                sel_ff <= dir_ff ? i_tx_empty_sel : i_rx_older_sel;
            end
            else if (state_ff == sbd_pkg::ST_MOVE && left_ff != 5'h00)
            begin
                left_ff <= left_ff - 5'h01;
                idx_ff <= idx_ff + 4'h1;
            end
        end
    end

    // -----------------------------------------------------------------
    // data movement
    // -----------------------------------------------------------------
    logic moving;
    assign moving = (state_ff == sbd_pkg::ST_MOVE) && (left_ff != 5'h00)
        && i_clk_en;

    // one byte per cycle each way
    always_comb
    begin
        o_ram.req = moving;
        o_ram.we = !dir_ff;
        o_ram.addr = addr_ff;
        o_ram.wdata = i_buf_rdata;
        o_buf.req = moving;
        o_buf.we = dir_ff;
        o_buf.tx = dir_ff;
        o_buf.sel = sel_ff;
        o_buf.idx = idx_ff;
        o_buf.wdata = i_ram_rdata;
    end

    // -----------------------------------------------------------------
    // core stall and interrupts
    // -----------------------------------------------------------------
    // core held from launch until done
    assign o_core_stall = (state_ff != sbd_pkg::ST_IDLE);

    assign o_port_irq = err_ff && i_port_irq_enable;

    // illegal access pulse on detected error
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            illegal_ff <= 1'b0;
        else if (i_clk_en)
            illegal_ff <= (state_ff == sbd_pkg::ST_SETUP) && bad
                && !i_illegal_irq_mask;
    end

    assign o_illegal_irq = illegal_ff;

endmodule : sbd_copy_engine

// ---- core/sbd_pkg.sv ----
// Purpose: shared constants and carriers of the serial buffer copy engine
// Assumes: classic wishbone, 8-bit register data in a 32-bit word
// Notes: byte addresses are four times the printed register index
package sbd_pkg;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL = 8'hDC;
    localparam logic [7:0] IDX_ADDR_LO = 8'hDD;
    localparam logic [7:0] IDX_ADDR_HI = 8'hDE;
    localparam logic [7:0] IDX_COUNT = 8'hDF;
    localparam logic [9:0] ADR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [9:0] ADR_ADDR_LO = {IDX_ADDR_LO, 2'b00};
    localparam logic [9:0] ADR_ADDR_HI = {IDX_ADDR_HI, 2'b00};
    localparam logic [9:0] ADR_COUNT = {IDX_COUNT, 2'b00};

    // -----------------------------------------------------------------
    // field positions and reset values
    // -----------------------------------------------------------------
    localparam int BIT_RUN = 0;
    localparam int BIT_DIR = 1;
    localparam int BIT_ERR = 2;
    localparam logic [11:0] RST_ADDR = 12'h100;
    localparam logic [4:0] RST_COUNT = 5'h00;
    localparam logic [11:0] RAM_LO = 12'h100;
    localparam logic [11:0] RAM_HI = 12'h8FF;
    localparam logic [4:0] BUF_BYTES = 5'h10;

    // -----------------------------------------------------------------
    // types
    // -----------------------------------------------------------------
    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_SETUP = 2'b01,
        ST_MOVE = 2'b11
    } sbd_state_type;

    // ram-side request carrier
    typedef struct packed
    {
        logic req;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } sbd_ram_req_type;

    // buffer-side request carrier
    typedef struct packed
    {
        logic req;
        logic we;
        logic tx;
        logic sel;
        logic [3:0] idx;
        logic [7:0] wdata;
    } sbd_buf_req_type;

endpackage : sbd_pkg

// ---- core/sbd_range_check.sv ----
// Purpose: launch-time range check of base address and byte count
// Assumes: purely combinational
// Notes: count of zero checks only the base
`timescale 1ns/1ps
module sbd_range_check
(
    // programmed values
    input wire logic [11:0] i_base,
    input wire logic [4:0] i_count,
    // verdict
    output logic o_bad
);

    // -----------------------------------------------------------------
    // check
    // -----------------------------------------------------------------
    logic [12:0] last_addr;

    // last location touched by the copy
    assign last_addr = {1'b0, i_base} + {8'h00, i_count}
        - ((i_count == 5'h00) ? 13'h0000 : 13'h0001);

    // base window check, end check, size check
    assign o_bad = (i_base < sbd_pkg::RAM_LO)
        || (i_base > sbd_pkg::RAM_HI)
        || (last_addr > {1'b0, sbd_pkg::RAM_HI})
        || (i_count > sbd_pkg::BUF_BYTES);

endmodule : sbd_range_check

// ---- dv/sbd_far_model.sv ----
// Purpose: ram and port buffer model facing the copy engine
// Assumes: reads answer in the request cycle
// Notes: idle read lines toggle so stale data never shows
`timescale 1ns/1ps
module sbd_far_model
(
    // engine side
    input wire logic i_ref_clk,
    input wire logic i_clear,
    input sbd_pkg::sbd_ram_req_type i_ram,
    input sbd_pkg::sbd_buf_req_type i_buf,
    output logic [7:0] o_ram_rdata,
    output logic [7:0] o_buf_rdata,
    // bench view
    output int o_reqs,
    output int o_bad,
    output logic [11:0] o_first,
    output logic o_sel
);
    logic noise_ff = 1'h0;
    // idle pattern flips each cycle
    always_ff @(posedge i_ref_clk)
        noise_ff <= ~noise_ff;
    assign o_ram_rdata = i_ram.req ? i_ram.addr[7:0] : {8{noise_ff}};
    assign o_buf_rdata = i_buf.req ? {3'h0, i_buf.sel, i_buf.idx} :
        {8{noise_ff}};
    // counts and checks each moved byte
    always_ff @(posedge i_ref_clk)
    begin
        if (i_clear)
        begin
            o_reqs <= 0;
            o_bad <= 0;
        end
        else if (i_ram.req)
        begin
            if (o_reqs == 0)
            begin
                o_first <= i_ram.addr;
                o_sel <= i_buf.sel;
            end
            o_reqs <= o_reqs + 1;
            if (i_ram.we ? i_ram.wdata !== o_buf_rdata :
                i_buf.wdata !== o_ram_rdata)
                o_bad <= o_bad + 1;
        end
    end
endmodule : sbd_far_model

// ---- dv/sbd_checker.sv ----
// Purpose: port assertions of the copy engine
// Assumes: one clock, asynchronous low reset
// Notes: bound from the bench top file
`timescale 1ns/1ps
module sbd_checker
(
    // watched ports
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [9:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic o_wb_ack,
    input wire logic i_port_enable,
    input wire logic i_buffer_mode,
    input wire logic i_port_irq_enable,
    input sbd_pkg::sbd_ram_req_type o_ram,
    input sbd_pkg::sbd_buf_req_type o_buf,
    input wire logic o_core_stall,
    input wire logic o_port_irq,
    input wire logic o_illegal_irq
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    logic [5:0] run_len_ff;
    // length of the current burst of ram requests
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            run_len_ff <= 6'h00;
        else
            run_len_ff <= o_ram.req ? run_len_ff + 6'h01 : 6'h00;
    end
    sequence s_launch;
        i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en && i_wb_we &&
        i_wb_adr == sbd_pkg::ADR_CTRL && i_wb_dat[0] && i_port_enable &&
        i_buffer_mode && !o_core_stall;
    endsequence
    sequence s_copy_done;
        o_core_stall ##[1:18] !o_core_stall;
    endsequence
    AST_LAUNCH_STALL: assert property ( // core held
        s_launch |=> s_copy_done) else $error("stall missing or too long");
    AST_ACK_ONE: assert property ( // every access answered
        i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en |=> o_wb_ack)
        else $error("ack late");
    AST_REQ_STALL: assert property ( // moves only while held
        o_ram.req |-> o_core_stall && o_buf.req) else $error("stray move");
    AST_ADDR_STEP: assert property ( // ram address steps
        o_ram.req && $past(o_ram.req) |->
        o_ram.addr == $past(o_ram.addr) + 12'h001) else $error("addr step");
    AST_IDX_FIRST: assert property ( // index starts at zero
        $rose(o_buf.req) |-> o_buf.idx == 4'h0) else $error("index start");
    AST_IDX_STEP: assert property ( // buffer index steps
        o_buf.req && $past(o_buf.req) |->
        o_buf.idx == $past(o_buf.idx) + 4'h1) else $error("index step");
    AST_DIR_PAIR: assert property ( // directions agree
        o_ram.req |-> o_buf.tx == o_buf.we && o_ram.we == !o_buf.we)
        else $error("direction mismatch");
    AST_WINDOW: assert property ( // inside ram window
        o_ram.req |-> o_ram.addr >= sbd_pkg::RAM_LO &&
        o_ram.addr <= sbd_pkg::RAM_HI) else $error("outside window");
    AST_RUN_MAX: assert property ( // burst length bound
        run_len_ff <= 6'h10) else $error("burst too long");
    AST_PORT_IRQ: assert property ( // port request gated
        o_port_irq |-> i_port_irq_enable) else $error("irq not gated");
    AST_ILL_PULSE: assert property ( // single pulse in the cycle after the check
        o_illegal_irq |-> !o_core_stall && $past(o_core_stall) ##1
        !o_illegal_irq) else $error("illegal pulse shape");
    AST_STALL_END: assert property ( // release after last byte
        $fell(o_ram.req) |-> ##[0:1] !o_core_stall) else $error("late end");
endmodule : sbd_checker

// ---- dv/sbd_copy_engine_test.sv ----
// Purpose: self-checking bench of the serial buffer copy engine
// Assumes: clock enable and all byte lanes held on
// Notes: register data sits in bits 7:0 of each word
`timescale 1ns/1ps
module sbd_copy_engine_test;
    logic clk = 1'h0, rst_n = 1'h0, req = 1'h0, we = 1'h0, clr = 1'h0;
    logic pen = 1'h1, bmode = 1'h1, pien = 1'h1, imask = 1'h0;
    logic txs = 1'h0, rxs = 1'h0, ack, stall, pirq, iirq, fsel;
    logic [9:0] adr = 10'h000;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [7:0] ram_rd, buf_rd;
    logic [11:0] first;
    sbd_pkg::sbd_ram_req_type ram;
    sbd_pkg::sbd_buf_req_type bq;
    int miscompares = 0, total_checks = 0, reqs, bad, pulses = 0, n;
    sbd_copy_engine dut_u
    (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'h1),
        .i_wb_cyc(req), .i_wb_stb(req), .i_wb_we(we), .i_wb_adr(adr),
        .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_port_enable(pen), .i_buffer_mode(bmode),
        .i_port_irq_enable(pien), .i_illegal_irq_mask(imask),
        .i_tx_empty_sel(txs), .i_rx_older_sel(rxs), .o_ram(ram),
        .i_ram_rdata(ram_rd), .o_buf(bq), .i_buf_rdata(buf_rd),
        .o_core_stall(stall), .o_port_irq(pirq), .o_illegal_irq(iirq)
    );
    sbd_far_model far_u
    (
        .i_ref_clk(clk), .i_clear(clr), .i_ram(ram), .i_buf(bq),
        .o_ram_rdata(ram_rd), .o_buf_rdata(buf_rd), .o_reqs(reqs),
        .o_bad(bad), .o_first(first), .o_sel(fsel)
    );
    // free-running reference clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // counts illegal access pulses
    always @(posedge clk)
    begin
        if (iirq === 1'h1)
            pulses <= pulses + 1;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // one classic cycle, ends on the ack edge
    task automatic wb(input logic w, input logic [9:0] a,
        input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        req <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= {24'h000000, d};
        @(posedge clk);
        while (ack !== 1'h1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        q = rdat;
        req <= 1'h0;
        if (k == 20)
        begin
            miscompares++;
            give_verdict();
        end
    endtask : wb
    task automatic rd(input string s, input logic [9:0] a,
        input logic [7:0] e);
        wb(1'h0, a, 8'h00);
        chk(s, {24'h000000, e}, q);
    endtask : rd
    task automatic prog(input logic [11:0] b, input logic [7:0] c);
        wb(1'h1, sbd_pkg::ADR_ADDR_LO, b[7:0]);
        wb(1'h1, sbd_pkg::ADR_ADDR_HI, {4'h0, b[11:8]});
        wb(1'h1, sbd_pkg::ADR_COUNT, c);
    endtask : prog
    // clears the model, sets run with flag bit one, counts held cycles
    task automatic launch(input logic d);
        @(posedge clk);
        clr <= 1'h1;
        @(posedge clk);
        clr <= 1'h0;
        wb(1'h1, sbd_pkg::ADR_CTRL, {5'h00, 1'h1, d, 1'h1});
        n = 0;
        while (stall === 1'h1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 40)
        begin
            miscompares++;
            give_verdict();
        end
    endtask : launch
    task automatic copy_ok(input logic d, input logic [11:0] b,
        input int c, input logic s);
        launch(d);
        chk("stall cycles", 32'(c + 1), 32'(n)); // length
        chk("bytes moved", 32'(c), 32'(reqs)); // count
        chk("first address", 32'(b), 32'(first)); // start
        chk("buffer select", 32'(s), 32'(fsel)); // buffer
        chk("data faults", 32'h0, 32'(bad)); // data
        rd("control", sbd_pkg::ADR_CTRL, {6'h00, d, 1'h0});
        rd("addr low", sbd_pkg::ADR_ADDR_LO, 8'(b + c)); // next
        rd("addr high", sbd_pkg::ADR_ADDR_HI, 8'((b + c) >> 8));
        rd("count kept", sbd_pkg::ADR_COUNT, 8'(c)); // kept
        $display("copy test done");
    endtask : copy_ok
    task automatic err_case(input logic [11:0] b, input logic [7:0] c,
        input logic m);
        int p;
        imask <= m;
        prog(b, c);
        p = pulses;
        launch(1'h0);
        repeat (2) @(posedge clk);
        chk("error stall", 32'h1, 32'(n)); // quick release
        chk("error bytes", 32'h0, 32'(reqs)); // nothing moved
        chk("illegal pulses", 32'(!m), 32'(pulses - p)); // mask
        chk("port irq", 32'h1, 32'(pirq)); // level
        rd("error flag", sbd_pkg::ADR_CTRL, 8'h04);
        rd("kept low", sbd_pkg::ADR_ADDR_LO, b[7:0]); // unchanged
        rd("kept high", sbd_pkg::ADR_ADDR_HI, {4'h0, b[11:8]});
        rd("kept count", sbd_pkg::ADR_COUNT, c); // unchanged
        $display("error test done");
    endtask : err_case
    task automatic t_reset();
        rd("ctrl reset", sbd_pkg::ADR_CTRL, 8'h00); // idle
        rd("low reset", sbd_pkg::ADR_ADDR_LO, 8'h00); // value
        rd("high reset", sbd_pkg::ADR_ADDR_HI, 8'h01); // value
        rd("count reset", sbd_pkg::ADR_COUNT, 8'h00); // value
        rd("unmapped", 10'h004, 8'h00); // empty word
        wb(1'h1, sbd_pkg::ADR_ADDR_HI, 8'hFF);
        wb(1'h1, sbd_pkg::ADR_COUNT, 8'hFF);
        rd("high masked", sbd_pkg::ADR_ADDR_HI, 8'h0F); // zeros
        rd("count masked", sbd_pkg::ADR_COUNT, 8'h1F); // zeros
        $display("reset test done");
    endtask : t_reset
    task automatic t_copies();
        txs <= 1'h1;
        prog(12'h100, 8'h10); // legal count
        copy_ok(1'h1, 12'h100, 16, 1'h1);
        txs <= 1'h0;
        rxs <= 1'h1;
        copy_ok(1'h0, 12'h110, 16, 1'h1); // chained
        rxs <= 1'h0;
        prog(12'h8FE, 8'h02);
        copy_ok(1'h0, 12'h8FE, 2, 1'h0);
    endtask : t_copies
    task automatic t_errors();
        err_case(12'h0FF, 8'h01, 1'h0);
        pien <= 1'h0;
        repeat (2) @(posedge clk);
        chk("irq gated", 32'h0, 32'(pirq)); // disabled
        pien <= 1'h1;
        wb(1'h1, sbd_pkg::ADR_CTRL, 8'h00);
        rd("flag cleared", sbd_pkg::ADR_CTRL, 8'h00); // by zero
        err_case(12'h8F8, 8'h09, 1'h1);
        err_case(12'h100, 8'h11, 1'h0);
        prog(12'h100, 8'h01);
        copy_ok(1'h0, 12'h100, 1, 1'h0); // flag cleared
    endtask : t_errors
    task automatic t_gates();
        bmode <= 1'h0;
        launch(1'h0);
        chk("launch gated", 32'h0, 32'(n)); // mode off
        bmode <= 1'h1;
        pen <= 1'h0;
        wb(1'h1, sbd_pkg::ADR_ADDR_LO, 8'h55);
        rd("port off read", sbd_pkg::ADR_ADDR_LO, 8'h00); // hidden
        pen <= 1'h1;
        rd("port off write", sbd_pkg::ADR_ADDR_LO, 8'h01); // kept
        $display("gate test done");
    endtask : t_gates
    // reset then every scenario in turn
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        t_reset();
        t_copies();
        t_errors();
        t_gates();
        give_verdict();
    end
endmodule : sbd_copy_engine_test
bind sbd_copy_engine sbd_checker chk_u
(
    .i_ref_clk, .i_rst_n, .i_clk_en, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_dat, .o_wb_ack, .i_port_enable, .i_buffer_mode,
    .i_port_irq_enable, .o_ram, .o_buf, .o_core_stall, .o_port_irq,
    .o_illegal_irq
);
